// ---- rtl/flash_cmd_pkg.sv ----
package flash_cmd_pkg;

    // ************************************************************
    // opcodes
    // ************************************************************
    localparam logic [7:0] OP_READ_FAST = 8'h0B;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_DUAL_OUT = 8'h3B;
    localparam logic [7:0] OP_READ_DUAL_IO = 8'hBB;
    localparam logic [7:0] OP_READ_QUAD_OUT = 8'h6B;
    localparam logic [7:0] OP_READ_QUAD_IO = 8'hEB;
    localparam logic [7:0] OP_CRM_RESET = 8'hFF;
    localparam logic [7:0] OP_ERASE_4K = 8'h20;
    localparam logic [7:0] OP_ERASE_32K = 8'h52;
    localparam logic [7:0] OP_ERASE_64K = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
    localparam logic [7:0] OP_CHIP_ERASE_B = 8'hC7;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;
    localparam logic [7:0] OP_STATUS_1 = 8'h05;
    localparam logic [7:0] OP_STATUS_2 = 8'h35;
    localparam logic [7:0] OP_WR_STATUS = 8'h01;
    localparam logic [7:0] OP_VOL_WREN = 8'h50;

    // ************************************************************
    // framing and array geometry
    // ************************************************************
    localparam logic [4:0] OPCODE_BITS = 5'h08;
    localparam logic [4:0] ADDR_FIELD_BITS = 5'h18;
    localparam logic [4:0] BYTE_BITS = 5'h08;
    localparam int ADDR_BITS = 21;
    localparam int BLK_4K_BITS = 12;
    localparam int BLK_32K_BITS = 15;
    localparam int BLK_64K_BITS = 16;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [8:0] WR_STATUS_MAX = 9'h002;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [2:0] LANE_1 = 3'h1;
    localparam logic [2:0] LANE_2 = 3'h2;
    localparam logic [2:0] LANE_4 = 3'h4;

    typedef enum logic [1:0] {DIR_NONE, DIR_IN, DIR_OUT} data_dir_t;

    typedef enum logic [2:0] {
        ST_OPCODE, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_CRM,
        ST_IGNORE, ST_HOLD
    } link_state_t;

    typedef struct packed {
        logic valid;
        logic has_addr;
        logic has_dummy;
        logic [2:0] addr_lanes;
        logic [2:0] data_lanes;
        data_dir_t dir;
        logic [8:0] max_in;
    } op_info_t;

endpackage

// ---- rtl/spi_flash_front.sv ----
`timescale 1ns/10ps
module spi_flash_front #(
    parameter int PAGE_MAX = 256
) (
    // system side
    input wire logic ref_clk,
    input wire logic rstn,
    // serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe,
    // decoded command
    output logic cmd_valid,
    output logic [7:0] cmd_op,
    output logic [20:0] cmd_addr,
    output logic cmd_dual,
    // write data stream
    output logic wr_valid,
    output logic [7:0] wr_data,
    // read data fetch
    output logic rd_req,
    input wire logic rd_valid,
    input wire logic [7:0] rd_data,
    // end of frame
    output logic done_valid,
    output logic done_ok,
    output logic [8:0] done_count
);

    // ************************************************************
    // decoding helpers
    // ************************************************************
    function automatic flash_cmd_pkg::op_info_t op_info(
        input logic [7:0] op
    );
        flash_cmd_pkg::op_info_t i;
        i = '0;
        i.addr_lanes = flash_cmd_pkg::LANE_1;
        i.data_lanes = flash_cmd_pkg::LANE_1;
        i.valid = 1'b1;
        case (op)
            flash_cmd_pkg::OP_READ_FAST,
            flash_cmd_pkg::OP_SEC_READ: begin
                i.has_addr = 1'b1;
                i.has_dummy = 1'b1;
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_READ_SLOW: begin
                i.has_addr = 1'b1;
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_READ_DUAL_OUT: begin
                i.has_addr = 1'b1;
                i.has_dummy = 1'b1;
                i.data_lanes = flash_cmd_pkg::LANE_2;
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_READ_DUAL_IO: begin
                i.has_addr = 1'b1;
                i.addr_lanes = flash_cmd_pkg::LANE_2;
                i.data_lanes = flash_cmd_pkg::LANE_2;
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_READ_QUAD_OUT: begin
                i.has_addr = 1'b1;
                i.has_dummy = 1'b1;
                i.data_lanes = flash_cmd_pkg::LANE_4;
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_READ_QUAD_IO: begin
                i.has_addr = 1'b1;
                i.has_dummy = 1'b1;
                i.addr_lanes = flash_cmd_pkg::LANE_4;
                i.data_lanes = flash_cmd_pkg::LANE_4;
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_ERASE_4K,
            flash_cmd_pkg::OP_ERASE_32K,
            flash_cmd_pkg::OP_ERASE_64K,
            flash_cmd_pkg::OP_SEC_ERASE: begin
                i.has_addr = 1'b1;
            end
            flash_cmd_pkg::OP_PROGRAM,
            flash_cmd_pkg::OP_SEC_PROGRAM: begin
                i.has_addr = 1'b1;
                i.dir = flash_cmd_pkg::DIR_IN;
                i.max_in = flash_cmd_pkg::PAGE_BYTES;
            end
            flash_cmd_pkg::OP_STATUS_1,
            flash_cmd_pkg::OP_STATUS_2: begin
                i.dir = flash_cmd_pkg::DIR_OUT;
            end
            flash_cmd_pkg::OP_WR_STATUS: begin
                i.dir = flash_cmd_pkg::DIR_IN;
                i.max_in = flash_cmd_pkg::WR_STATUS_MAX;
            end
            flash_cmd_pkg::OP_CHIP_ERASE_A,
            flash_cmd_pkg::OP_CHIP_ERASE_B,
            flash_cmd_pkg::OP_SUSPEND,
            flash_cmd_pkg::OP_RESUME,
            flash_cmd_pkg::OP_WR_ENABLE,
            flash_cmd_pkg::OP_WR_DISABLE,
            flash_cmd_pkg::OP_VOL_WREN,
            flash_cmd_pkg::OP_CRM_RESET: begin
                i.has_addr = 1'b0;
            end
            default: begin
                i.valid = 1'b0;
            end
        endcase
        return i;
    endfunction

    // 4K, 32K and 64K erase addresses snap down to their block boundary
    function automatic logic [20:0] align_addr(
        input logic [7:0] op,
        input logic [23:0] a
    );
        logic [20:0] m;
        m = a[flash_cmd_pkg::ADDR_BITS-1:0];
        case (op)
            flash_cmd_pkg::OP_ERASE_4K: begin
                m = (m >> flash_cmd_pkg::BLK_4K_BITS)
                    << flash_cmd_pkg::BLK_4K_BITS;
            end
            flash_cmd_pkg::OP_ERASE_32K: begin
                m = (m >> flash_cmd_pkg::BLK_32K_BITS)
                    << flash_cmd_pkg::BLK_32K_BITS;
            end
            flash_cmd_pkg::OP_ERASE_64K: begin
                m = (m >> flash_cmd_pkg::BLK_64K_BITS)
                    << flash_cmd_pkg::BLK_64K_BITS;
            end
            default: begin
                m = m;
            end
        endcase
        return m;
    endfunction

    // ************************************************************
    // parameter check
    // ************************************************************
    if (PAGE_MAX < 1 || PAGE_MAX > 256) begin : g_bad_page
        $error("PAGE_MAX must lie in 1..256");
    end

    localparam logic [8:0] PAGE_LIMIT = 9'(PAGE_MAX);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // select high clears the link side at once, so a frame cut
    // short leaves nothing behind
    logic link_rst_n;
    assign link_rst_n = rst_n & ~cs_n;

    // ************************************************************
    // link side, rising edge: framing and decode
    // ************************************************************
    flash_cmd_pkg::link_state_t state;
    flash_cmd_pkg::link_state_t next_state;
    flash_cmd_pkg::op_info_t info;
    flash_cmd_pkg::op_info_t new_info;
    logic [7:0] op;
    logic [4:0] cnt;
    logic [23:0] sh;
    logic [23:0] next_sh;
    logic [8:0] wcnt;
    logic [8:0] wr_limit;
    logic [2:0] lanes;
    logic [4:0] len;
    logic [4:0] next_cnt;
    logic last;

    always_comb begin
        lanes = flash_cmd_pkg::LANE_1;
        if (state == flash_cmd_pkg::ST_ADDR ||
            state == flash_cmd_pkg::ST_DUMMY) begin
            lanes = info.addr_lanes;
        end
        len = flash_cmd_pkg::BYTE_BITS;
        if (state == flash_cmd_pkg::ST_OPCODE) begin
            len = flash_cmd_pkg::OPCODE_BITS;
        end else if (state == flash_cmd_pkg::ST_ADDR) begin
            len = flash_cmd_pkg::ADDR_FIELD_BITS;
        end
        next_cnt = cnt + {2'b00, lanes};
        last = (next_cnt == len);
        // first bit in lands highest
        case (lanes)
            flash_cmd_pkg::LANE_2: next_sh = {sh[21:0], io_in[1:0]};
            flash_cmd_pkg::LANE_4: next_sh = {sh[19:0], io_in};
            default: next_sh = {sh[22:0], io_in[0]};
        endcase
        new_info = op_info(next_sh[7:0]);
        wr_limit = (info.max_in > PAGE_LIMIT) ? PAGE_LIMIT
                                              : info.max_in;
    end

    always_comb begin
        next_state = state;
        if (last) begin
            unique case (state)
                flash_cmd_pkg::ST_OPCODE: begin
                    if (!new_info.valid) begin
                        next_state = flash_cmd_pkg::ST_IGNORE;
                    end else if (next_sh[7:0] ==
                                 flash_cmd_pkg::OP_CRM_RESET) begin
                        next_state = flash_cmd_pkg::ST_CRM;
                    end else if (new_info.has_addr) begin
                        next_state = flash_cmd_pkg::ST_ADDR;
                    end else if (new_info.dir ==
                                 flash_cmd_pkg::DIR_IN) begin
                        next_state = flash_cmd_pkg::ST_WDATA;
                    end else if (new_info.dir ==
                                 flash_cmd_pkg::DIR_OUT) begin
                        next_state = flash_cmd_pkg::ST_RDATA;
                    end else begin
                        next_state = flash_cmd_pkg::ST_HOLD;
                    end
                end
                flash_cmd_pkg::ST_ADDR: begin
                    if (info.has_dummy) begin
                        next_state = flash_cmd_pkg::ST_DUMMY;
                    end else if (info.dir == flash_cmd_pkg::DIR_IN) begin
                        next_state = flash_cmd_pkg::ST_WDATA;
                    end else if (info.dir == flash_cmd_pkg::DIR_OUT) begin
                        next_state = flash_cmd_pkg::ST_RDATA;
                    end else begin
                        next_state = flash_cmd_pkg::ST_HOLD;
                    end
                end
                flash_cmd_pkg::ST_DUMMY: begin
                    next_state = flash_cmd_pkg::ST_RDATA;
                end
                flash_cmd_pkg::ST_CRM: begin
                    next_state = flash_cmd_pkg::ST_HOLD;
                end
                flash_cmd_pkg::ST_WDATA,
                flash_cmd_pkg::ST_RDATA,
                flash_cmd_pkg::ST_IGNORE,
                flash_cmd_pkg::ST_HOLD: begin
                    next_state = state;
                end
            endcase
        end
    end

    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state <= flash_cmd_pkg::ST_OPCODE;
            cnt <= 5'h00;
            sh <= 24'h000000;
            op <= 8'h00;
            info <= '0;
        end else begin
            state <= next_state;
            sh <= next_sh;
            cnt <= last ? 5'h00 : next_cnt;
            if (state == flash_cmd_pkg::ST_OPCODE && last) begin
                op <= next_sh[7:0];
                info <= new_info;
            end
        end
    end

    // bytes past the limit are dropped, not passed on
    always_ff @(posedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            wcnt <= 9'h000;
        end else if (state == flash_cmd_pkg::ST_WDATA && last &&
                     wcnt < wr_limit) begin
            wcnt <= wcnt + 9'h001;
        end
    end

    // event words and toggles live through select so the crossing
    // never loses an edge
    logic cmd_tog;
    logic [7:0] cmd_op_l;
    logic [20:0] cmd_addr_l;
    logic cmd_dual_l;
    logic wr_tog;
    logic [7:0] wr_byte_l;

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            cmd_tog <= 1'b0;
            cmd_op_l <= 8'h00;
            cmd_addr_l <= 21'h000000;
            cmd_dual_l <= 1'b0;
        end else if (cs_n) begin
            cmd_tog <= cmd_tog;
        end else if (last && state == flash_cmd_pkg::ST_OPCODE &&
                     new_info.valid && !new_info.has_addr) begin
            cmd_tog <= ~cmd_tog;
            cmd_op_l <= next_sh[7:0];
            cmd_addr_l <= 21'h000000;
            cmd_dual_l <= 1'b0;
        end else if (last && state == flash_cmd_pkg::ST_ADDR) begin
            cmd_tog <= ~cmd_tog;
            cmd_op_l <= op;
            cmd_addr_l <= align_addr(op, next_sh);
            cmd_dual_l <= 1'b0;
        end else if (last && state == flash_cmd_pkg::ST_CRM &&
                     next_sh[7:0] == flash_cmd_pkg::OP_CRM_RESET) begin
            cmd_tog <= ~cmd_tog;
            cmd_dual_l <= 1'b1;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            wr_tog <= 1'b0;
            wr_byte_l <= 8'h00;
        end else if (!cs_n && state == flash_cmd_pkg::ST_WDATA &&
                     last && wcnt < wr_limit) begin
            wr_tog <= ~wr_tog;
            wr_byte_l <= next_sh[7:0];
        end
    end

    // ************************************************************
    // link side, falling edge: output lanes and data fetch
    // ************************************************************
    logic want_data;
    logic started;
    logic req_tog;
    logic ack_tog;
    logic ack_meta;
    logic ack_sync;
    logic have_data;
    logic [7:0] hold;
    logic [7:0] ob;
    logic [7:0] cur;
    logic [2:0] ocnt;
    logic [2:0] dl;

    assign want_data = state == flash_cmd_pkg::ST_DUMMY ||
                       state == flash_cmd_pkg::ST_RDATA;
    assign have_data = started && (ack_sync == req_tog);
    assign dl = info.data_lanes;
    // a byte not yet fetched goes out as all ones
    assign cur = (ocnt != 3'h0) ? ob :
                 have_data ? hold : flash_cmd_pkg::IDLE_BYTE;

    always_ff @(negedge sck or negedge rst_n) begin
        if (!rst_n) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            ack_meta <= ack_tog;
            ack_sync <= ack_meta;
        end
    end

    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            started <= 1'b0;
        end else begin
            started <= started | want_data;
        end
    end

    always_ff @(negedge sck or negedge rst_n) begin
        if (!rst_n) begin
            req_tog <= 1'b0;
        end else if (!cs_n && want_data && (!started ||
                     (state == flash_cmd_pkg::ST_RDATA &&
                      ocnt == 3'h0 && have_data))) begin
            req_tog <= ~req_tog;
        end
    end

    always_ff @(negedge sck or negedge link_rst_n) begin
        if (!link_rst_n) begin
            io_out <= 4'h0;
            io_oe <= 4'h0;
            ob <= 8'h00;
            ocnt <= 3'h0;
        end else if (state == flash_cmd_pkg::ST_RDATA) begin
            ob <= cur << dl;
            ocnt <= ocnt + dl;
            case (dl)
                flash_cmd_pkg::LANE_2: begin
                    io_out <= {2'b00, cur[7:6]};
                    io_oe <= 4'h3;
                end
                flash_cmd_pkg::LANE_4: begin
                    io_out <= cur[7:4];
                    io_oe <= 4'hF;
                end
                default: begin
                    io_out <= {2'b00, cur[7], 1'b0};
                    io_oe <= 4'h2;
                end
            endcase
        end else begin
            io_oe <= 4'h0;
        end
    end

    // ************************************************************
    // system side: crossings
    // ************************************************************
    logic [3:0] cs_pipe;
    logic [2:0] cmd_pipe;
    logic [2:0] wr_pipe;
    logic [2:0] req_pipe;
    logic pending;
    logic seen_cmd;
    flash_cmd_pkg::op_info_t done_info;

    // select takes one stage more than the toggles, so a last byte
    // is counted before its frame closes
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_pipe <= 4'hF;
            cmd_pipe <= 3'h0;
            wr_pipe <= 3'h0;
            req_pipe <= 3'h0;
        end else begin
            cs_pipe <= {cs_pipe[2:0], cs_n};
            cmd_pipe <= {cmd_pipe[1:0], cmd_tog};
            wr_pipe <= {wr_pipe[1:0], wr_tog};
            req_pipe <= {req_pipe[1:0], req_tog};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_valid <= 1'b0;
            cmd_op <= 8'h00;
            cmd_addr <= 21'h000000;
            cmd_dual <= 1'b0;
        end else begin
            cmd_valid <= cmd_pipe[2] ^ cmd_pipe[1];
            if (cmd_pipe[2] ^ cmd_pipe[1]) begin
                cmd_op <= cmd_op_l;
                cmd_addr <= cmd_addr_l;
                cmd_dual <= cmd_dual_l;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid <= 1'b0;
            wr_data <= 8'h00;
        end else begin
            wr_valid <= wr_pipe[2] ^ wr_pipe[1];
            if (wr_pipe[2] ^ wr_pipe[1]) begin
                wr_data <= wr_byte_l;
            end
        end
    end

    // one answer per request; hold stays put until the next one
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_req <= 1'b0;
            pending <= 1'b0;
            ack_tog <= 1'b0;
            hold <= 8'h00;
        end else begin
            rd_req <= req_pipe[2] ^ req_pipe[1];
            if (req_pipe[2] ^ req_pipe[1]) begin
                pending <= 1'b1;
            end else if (pending && rd_valid) begin
                pending <= 1'b0;
                hold <= rd_data;
                ack_tog <= ~ack_tog;
            end
        end
    end

    assign done_info = op_info(cmd_op);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_cmd <= 1'b0;
            done_valid <= 1'b0;
            done_ok <= 1'b0;
            done_count <= 9'h000;
        end else if (cs_pipe[2] && !cs_pipe[3]) begin
            seen_cmd <= 1'b0;
            done_valid <= 1'b1;
            done_ok <= seen_cmd &&
                       (done_info.dir != flash_cmd_pkg::DIR_IN ||
                        done_count != 9'h000);
        end else begin
            done_valid <= 1'b0;
            if (cs_pipe[2] && done_valid) begin
                done_count <= 9'h000;
            end else if (cmd_pipe[2] ^ cmd_pipe[1]) begin
                seen_cmd <= 1'b1;
                done_count <= 9'h000;
            end else if (wr_pipe[2] ^ wr_pipe[1]) begin
                done_count <= done_count + 9'h001;
            end
        end
    end

endmodule

// ---- test/spi_flash_front_chk.sv ----
`timescale 1ns/10ps
module spi_flash_front_chk (
    input wire logic ref_clk, rstn, cs_n, cmd_valid, wr_valid, done_valid,
    input wire logic [3:0] io_oe,
    input wire logic [7:0] cmd_op,
    input wire logic [20:0] cmd_addr
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    AST_CMD_PULSE: assert property (cmd_valid |=> !cmd_valid)
        else $error("cmd_valid held");
    AST_IDLE_OE: assert property (cs_n |-> io_oe == 4'h0)
        else $error("pins driven while deselected");
    AST_QUAD_OE: assert property (io_oe == 4'hF |-> ##[0:5]
        cmd_op inside {8'h6B, 8'hEB}) else $error("quad drive");
    AST_DUAL_OE: assert property (io_oe == 4'h3 |-> ##[0:5]
        cmd_op inside {8'h3B, 8'hBB}) else $error("dual drive");
    AST_WR_OP: assert property (wr_valid |->
        cmd_op inside {8'h02, 8'h42, 8'h01}) else $error("stray write");
    AST_ALIGN_4K: assert property (cmd_valid && cmd_op == 8'h20 |->
        cmd_addr[11:0] == 12'h000) else $error("4k align");
    AST_ALIGN_64K: assert property (cmd_valid && cmd_op == 8'hD8 |->
        cmd_addr[15:0] == 16'h0000) else $error("64k align");
    AST_BARE: assert property (cmd_valid && cmd_op inside
        {8'h06, 8'h04, 8'h75, 8'h7A, 8'h60, 8'hC7} |-> cmd_addr == 21'h0)
        else $error("bare op with address");
    AST_DONE_CS: assert property (done_valid |-> cs_n && $past(cs_n, 3))
        else $error("done without release");
endmodule
bind spi_flash_front spi_flash_front_chk u_chk (.*);

// ---- test/spi_host.sv ----
`timescale 1ns/10ps
module spi_host (
    output logic sck, cs_n,
    output wire logic [3:0] io_in,
    input wire logic [3:0] io_out, io_oe
);
    logic [3:0] hd = 4'h0, he = 4'h0;
    logic mode3 = 1'b0;
    // wp/hold pulled high; si/so released show inverse of last value
    assign io_in = io_oe & io_out | ~io_oe & (he & hd
        | ~he & {2'b11, ~hd[1:0]});
    initial {sck, cs_n} = 2'b01;
    task sel(input logic v);
        // idle level set while deselected, so the edge is harmless
        if (!v) sck = mode3;
        #40 cs_n = v;
        #20 sck = v & mode3;
        #20;
    endtask
    task send(input logic [31:0] v, input int n, w);
        logic [31:0] s;
        he = w == 4 ? 4'hF : w == 2 ? 4'h3 : 4'h1;
        for (int i = 0; i < n; i += w) begin
            s = v << i;
            hd = 4'(s[31:28] >> (4 - w));
            #31 sck = 1'b1;
            #62.5 sck = 1'b0;
            #31.5;
        end
        he = 4'h0;
    endtask
    task recv(input int w, output logic [7:0] b);
        b = 8'h00;
        for (int i = 0; i < 8; i += w) begin
            #31 sck = 1'b1;
            b = w == 1 ? {b[6:0], io_in[1]} : w == 2 ? {b[5:0], io_in[1:0]}
                : {b[3:0], io_in};
            #62.5 sck = 1'b0;
            #31.5;
        end
    endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/10ps
module tb;
    logic ref_clk, rstn, rd_valid;
    logic sck, cs_n, cmd_valid, cmd_dual, wr_valid, rd_req;
    logic done_valid, done_ok;
    logic [3:0] io_in, io_out, io_oe;
    logic [7:0] cmd_op, wr_data, rd_data, b, e;
    logic [20:0] cmd_addr;
    logic [8:0] done_count;
    logic [23:0] a;
    logic [31:0] seed = 32'h69B99FC6;
    logic [7:0] rq[$], wq[$];
    int n_fail = 0, tests_run = 0, ncmd = 0;
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    spi_host h (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
        .io_oe(io_oe));
    spi_flash_front DUT (.ref_clk(ref_clk), .rstn(rstn), .sck(sck),
        .cs_n(cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_dual(cmd_dual), .wr_valid(wr_valid), .wr_data(wr_data),
        .rd_req(rd_req), .rd_valid(rd_valid), .rd_data(rd_data),
        .done_valid(done_valid), .done_ok(done_ok),
        .done_count(done_count));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [20:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        ncmd += cmd_valid === 1'b1;
        if (wr_valid === 1'b1) wq.push_back(wr_data);
        rd_valid <= #1 rd_req;
        if (rd_req === 1'b1) begin
            seed = xs(seed);
            rd_data <= #1 seed[7:0];
            rq.push_back(seed[7:0]);
        end
    end
    task automatic fin(input logic ok, input logic [8:0] c = 9'h1FF);
        int k;
        h.sel(1'b1);
        for (k = 0; k < 20 && done_valid !== 1'b1; k++) @(negedge ref_clk);
        if (k == 20) begin
            n_fail++;
            conclude();
        end
        chk("done_ok", done_ok, ok);
        // the count stands only while the frame-end pulse does
        if (c != 9'h1FF) chk("done_count", done_count, c);
        repeat (6) @(negedge ref_clk);
    endtask
    initial begin
        logic [7:0] op[13] = '{8'h06, 8'h04, 8'h75, 8'h7A, 8'h60, 8'hC7,
            8'h05, 8'h35, 8'h50, 8'h20, 8'h52, 8'hD8, 8'h44};
        logic [20:0] m[13] = '{0, 0, 0, 0, 0, 0, 0, 0, 0,
            21'h1FF000, 21'h1F8000, 21'h1F0000, 21'h1FFFFF};
        rstn = 1'b0;
        repeat (8) @(posedge ref_clk);
        #1 rstn = 1'b1;
        repeat (4) @(posedge ref_clk);
        foreach (op[i]) begin
            h.mode3 = 1'(i % 2);
            seed = xs(seed);
            a = seed[23:0];
            h.sel(1'b0);
            h.send({op[i], a}, 32, 1);
            fin(1'b1);
            chk("cmd_op", cmd_op, op[i]);
            chk("cmd_addr", cmd_addr, a[20:0] & m[i]);
        end
        for (int i = 0; i < 2; i++) begin
            a = seed[23:0];
            wq.delete();
            h.sel(1'b0);
            h.send({i ? 8'h01 : 8'h02, a}, 32, 1);
            if (i == 0) h.send({a, 8'h00}, 24, 1);
            fin(1'b1, i ? 9'h002 : 9'h003);
            for (int j = 0; j < 3 - i; j++)
                chk("wr_data", wq[j], a[23 - 8 * j -: 8]);
        end
        ncmd = 0;
        h.sel(1'b0);
        h.send(32'hA5123456, 32, 1);
        fin(1'b0);
        h.sel(1'b0);
        h.send(32'h02120000, 16, 1);
        fin(1'b0);
        chk("cmd count", ncmd, 0);
        for (int i = 0; i < 2; i++) begin
            h.sel(1'b0);
            h.send(32'hFFFF0000, 8 * (i + 1), 1);
            fin(1'b1);
            chk("cmd_dual", cmd_dual, i);
        end
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            a = seed[23:0];
            rq.delete();
            h.mode3 = 1'(i % 2);
            h.sel(1'b0);
            h.send({i == 0 ? 8'h0B : i == 1 ? 8'h3B : 8'h6B, a}, 32, 1);
            h.send(32'h0, 8, 1);
            for (int j = 0; j < 3; j++) begin
                h.recv(1 << i, b);
                // quad drains a byte in two clocks, before a fetch returns
                e = rq[(i == 2 && j == 2) ? 1 : j];
                if (i == 2 && j == 1) e = flash_cmd_pkg::IDLE_BYTE;
                chk("read data", b, e);
            end
            fin(1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            a = seed[23:0];
            h.sel(1'b0);
            h.send({i ? 8'hEB : 8'hBB, 24'h0}, 8, 1);
            h.send({a, 8'h00}, i ? 32 : 24, i ? 4 : 2);
            fin(1'b1);
            chk("cmd_addr", cmd_addr, a[20:0]);
        end
        conclude();
    end
endmodule
